// ### mono_capture_pkg.sv
// Shared constants, enumerations and carrier types for the monochrome capture core
package mono_capture_pkg;
	localparam int CORE_CLK_KHZ = 250000;   // Core clock, 4 ns period
	localparam int PIX_MIN_KHZ  = 11660;    // Slowest pixel clock
	localparam int PIX_MAX_KHZ  = 31000;    // Fastest pixel clock
	localparam int ACC_W        = 16;       // Phase accumulator width
	// Step limits: least rate rounds up, greatest rate rounds down
	localparam logic [ACC_W-1:0] STEP_MIN = ACC_W'((PIX_MIN_KHZ * 65536 + CORE_CLK_KHZ - 1) / CORE_CLK_KHZ);
	localparam logic [ACC_W-1:0] STEP_MAX = ACC_W'((PIX_MAX_KHZ * 65536) / CORE_CLK_KHZ);
	localparam int SAMPLE_W   = 8;          // Digitizer sample width
	localparam int LUT_DEPTH  = 256;        // Lookup table entries
	localparam int CNT_W      = 12;         // Pixel, line and frame counter width
	localparam int FIFO_BYTES = 4096;       // Capture store size
	localparam int FIFO_WORDS = FIFO_BYTES / 4;
	localparam int FIFO_AW    = 10;         // Address width of the store
	localparam int NUM_CHAN   = 3;          // Transfer channels
	localparam logic [1:0] LAST_CHAN = 2'h2;
	localparam logic [1:0] LAST_BYTE = 2'h3;

	// Trigger output source
	typedef enum logic [1:0] {EXTERNAL_TRIGGER_LINE_OUT_LOW, EXTERNAL_TRIGGER_LINE_OUT_HIGH, EXTERNAL_TRIGGER_LINE_OUT_HSYNC, EXTERNAL_TRIGGER_LINE_OUT_VSYNC} external_trigger_line_out_t;

	// Acquisition sequencer
	typedef enum logic [2:0] {ACQ_IDLE, ACQ_START_WAIT, ACQ_ARMED, ACQ_RUN, ACQ_STOP_WAIT} acq_state_t;

	// Window: origin and extent
	typedef struct packed {
		logic [CNT_W-1:0] start;
		logic [CNT_W-1:0] len;
	} win_t;

	// Packed word headed for the transfer channels
	typedef struct packed {
		logic [31:0]      data;         // Up to four pixels, first pixel in low byte
		logic [3:0]       be;           // Byte enables: 8, 16, 24 or 32 bit write
		logic [1:0]       chan;         // Channel that carries this frame
		logic [CNT_W-1:0] line;         // Line position in the merged frame
		logic             sof;          // First word of a frame
		logic             eol;          // Last word of a line
	} word_t;
endpackage : mono_capture_pkg

// ### mono_capture_core.sv
// Monochrome capture core: lookup, sync timing, windows, decimation, sequencing and word store
// Overview of operation
// - Each sample replaced through 256-entry lookup table
// - Sync source selectable; composite out only from video
// - Pixel clock held between 11.66 and 31 MHz
// - Horizontal total sets pixels per line period
// - Pixels kept only inside horizontal window
// - Lines kept only inside vertical window
// - Total lines per picture is programmable
// - Optional nested region of interest window
// - Horizontal decimation by 1, 2, 4, 8
// - Vertical decimation: all, odd, sparser odd lines
// - Decimation and region of interest combine
// - Interlaced fields merged; otherwise field is frame
// - First field of frame holds odd lines
// - Software start, stop and frame count
// - Trigger input starts on chosen edge
// - Start and stop immediate or frame delayed
// - Interlaced frame start on chosen parity
// - Trigger direction and output source programmable
// - Pixels pass through a 4 KB store
// - Three channels carry frames to descriptor chains
// - Words written as 8, 16, 24 or 32 bits
// - External composite sync drives all timing
`timescale 1ns/1ps
`default_nettype none
module mono_capture_core import mono_capture_pkg::*; (
	input  wire logic                core_clk_i,      // 250 MHz core clock
	input  wire logic                srst_i,          // Synchronous reset, active high
	input  wire logic [SAMPLE_W-1:0] sample_i,        // Digitized positive-polarity sample
	input  wire logic                video_hsync_i,   // Horizontal sync stripped from video
	input  wire logic                video_vsync_i,   // Vertical sync stripped from video
	input  wire logic                ext_hsync_i,     // Horizontal sync from external composite sync
	input  wire logic                ext_vsync_i,     // Vertical sync from external composite sync
	input  wire logic                sync_src_ext_i,  // 1: external composite sync feeds timing
	input  wire logic                composite_sync_out_en_i,  // Request composite sync out on connector
	output logic                     composite_sync_o,
	output logic                     composite_sync_oe_n_o,
	input  wire logic                lut_we_i,        // Lookup table write strobe
	input  wire logic [7:0]          lut_addr_i,
	input  wire logic [7:0]          lut_data_i,
	input  wire logic [ACC_W-1:0]    pix_step_i,      // Pixel rate as fraction of core clock
	input  wire logic [CNT_W-1:0]    htotal_i,        // Pixel periods per line
	input  wire logic [CNT_W-1:0]    line_total_i,    // Lines per picture, 525 or 625 typical
	input  wire win_t                acq_h_i,         // Acquisition window, pixels from hsync
	input  wire win_t                acq_v_i,         // Acquisition window, lines from vsync
	input  wire logic                roi_en_i,
	input  wire win_t                roi_h_i,         // Relative to acquisition window origin
	input  wire win_t                roi_v_i,
	input  wire logic [1:0]          hdec_i,          // Keep every 1, 2, 4, 8 pixels
	input  wire logic [1:0]          vdec_i,          // All, odd, every 2nd odd, every 4th odd
	input  wire logic                interlaced_i,
	input  wire logic                start_odd_i,     // Interlaced frame starts on odd field
	input  wire logic                start_sw_i,      // Start pulse
	input  wire logic                stop_sw_i,       // Stop pulse
	input  wire logic [CNT_W-1:0]    frame_count_i,   // Frames per acquisition, 0 runs forever
	input  wire logic [CNT_W-1:0]    start_delay_i,   // Frames to wait after start
	input  wire logic [CNT_W-1:0]    stop_delay_i,    // Frames to wait after stop
	input  wire logic                external_trigger_line_in_i,       // external_trigger_line input level
	output logic                     external_trigger_line_out_o,      // external_trigger_line output level
	output logic                     external_trigger_line_oe_n_o,     // Low while driving the trigger line
	input  wire logic                external_trigger_line_dir_in_i,   // 1: trigger line is an input
	input  wire logic                external_trigger_line_rise_i,     // 1: rising edge starts
	input  wire external_trigger_line_out_t           external_trigger_line_mode_i,
	output logic                     acq_busy_o,      // Sequencer not idle
	output logic                     overflow_o,      // Store was full, words lost
	output word_t                    out_word_o,
	output logic                     out_valid_o,
	input  wire logic                out_ready_i
);
	// Mask of low position bits that must be zero for a kept pixel or line
	function automatic logic [2:0] dec_mask(input logic [1:0] sel);
		dec_mask = 3'((4'h1 << sel) - 4'h1);
	endfunction : dec_mask
	// True when pos falls inside start .. start+len-1
	function automatic logic in_win(input logic [CNT_W-1:0] pos, input win_t w);
		in_win = (pos >= w.start) && ({1'b0, pos} < ({1'b0, w.start} + {1'b0, w.len}));
	endfunction : in_win

	logic [SAMPLE_W-1:0] sample_lookup_table [LUT_DEPTH];   // Transfer function RAM
	word_t               fifo_mem [FIFO_WORDS];             // 4 KB capture store

	// Timing group
	logic [ACC_W-1:0] acc, next_acc;              // Pixel phase accumulator
	logic [CNT_W-1:0] hcnt, next_hcnt;            // Pixel position in line
	logic [CNT_W-1:0] vcnt, next_vcnt;            // Line position in field
	logic             hs_prev, vs_prev, external_trigger_line_prev;
	logic             parity_odd, next_parity_odd;
	logic             field_first, next_field_first;
	logic [ACC_W-1:0] step_eff;
	logic             pix_en, hs_sel, vs_sel, hs_edge, vs_edge, frame_tick, external_trigger_line_edge;

	// Sync source selection: external composite sync replaces video-derived timing
	always_comb begin
		hs_sel = sync_src_ext_i ? ext_hsync_i : video_hsync_i;
		vs_sel = sync_src_ext_i ? ext_vsync_i : video_vsync_i;
		hs_edge = hs_sel && !hs_prev;
		vs_edge = vs_sel && !vs_prev;
		// Composite sync leaves only when derived from video; otherwise it is an input
		composite_sync_o = video_hsync_i | video_vsync_i;
		composite_sync_oe_n_o = sync_src_ext_i || !composite_sync_out_en_i;
		// Clamp keeps the generated pixel rate legal whatever software writes
		if (pix_step_i < STEP_MIN) begin
			step_eff = STEP_MIN;
		end else if (pix_step_i > STEP_MAX) begin
			step_eff = STEP_MAX;
		end else begin
			step_eff = pix_step_i;
		end
		pix_en = ({1'b0, acc} + {1'b0, step_eff}) > {1'b0, {ACC_W{1'b1}}};
		external_trigger_line_edge = external_trigger_line_dir_in_i && (external_trigger_line_rise_i ? (external_trigger_line_in_i && !external_trigger_line_prev) : (!external_trigger_line_in_i && external_trigger_line_prev));
	end

	// Next pixel, line and field position
	always_comb begin
		next_acc = acc + step_eff;
		next_hcnt = hcnt;
		next_vcnt = vcnt;
		next_parity_odd = parity_odd;
		next_field_first = field_first;
		frame_tick = 1'b0;
		if (vs_edge) begin
			// Field start; in interlaced mode a frame opens only on the chosen parity
			next_vcnt = '0;
			next_hcnt = '0;
			next_parity_odd = !parity_odd;
			next_field_first = !interlaced_i || (!parity_odd == start_odd_i);
			frame_tick = next_field_first;
		end else if (hs_edge || (pix_en && hcnt == htotal_i - 12'h001)) begin
			// Incoming sync locks the line; the horizontal total flywheels a missed sync
			next_hcnt = '0;
			next_vcnt = (vcnt >= line_total_i - 12'h001) ? '0 : vcnt + 12'h001;
		end else if (pix_en) begin
			next_hcnt = hcnt + 12'h001;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			acc <= '0;
			hcnt <= '0;
			vcnt <= '0;
			hs_prev <= 1'b0;
			vs_prev <= 1'b0;
			external_trigger_line_prev <= 1'b0;
			parity_odd <= 1'b0;
			field_first <= 1'b1;
		end else begin
			acc <= next_acc;
			hcnt <= next_hcnt;
			vcnt <= next_vcnt;
			hs_prev <= hs_sel;
			vs_prev <= vs_sel;
			external_trigger_line_prev <= external_trigger_line_in_i;
			parity_odd <= next_parity_odd;
			field_first <= next_field_first;
		end
	end

	// Trigger line: input for starts, or driven level or internal sync
	always_comb begin
		external_trigger_line_oe_n_o = external_trigger_line_dir_in_i;
		case (external_trigger_line_mode_i)
			EXTERNAL_TRIGGER_LINE_OUT_LOW:   external_trigger_line_out_o = 1'b0;
			EXTERNAL_TRIGGER_LINE_OUT_HIGH:  external_trigger_line_out_o = 1'b1;
			EXTERNAL_TRIGGER_LINE_OUT_HSYNC: external_trigger_line_out_o = hs_sel;
			default:        external_trigger_line_out_o = vs_sel;
		endcase
	end

	// Acquisition sequencer group
	acq_state_t       state, next_state;
	logic [CNT_W-1:0] fcnt, next_fcnt;          // Frames counted in wait or run
	logic [1:0]       chan, next_chan;          // Channel for the current frame
	logic             start_req, capturing;

	always_comb begin
		start_req = start_sw_i || external_trigger_line_edge;
		next_state = state;
		next_fcnt = fcnt;
		next_chan = chan;
		case (state)
			ACQ_IDLE: begin
				next_fcnt = '0;
				if (start_req) begin
					next_state = (start_delay_i == '0) ? ACQ_ARMED : ACQ_START_WAIT;
				end
			end
			ACQ_START_WAIT: begin
				if (stop_sw_i) begin
					next_state = ACQ_IDLE;
				end else if (frame_tick) begin
					next_fcnt = fcnt + 12'h001;
					if (fcnt + 12'h001 >= start_delay_i) begin
						next_state = ACQ_ARMED;
					end
				end
			end
			ACQ_ARMED: begin
				// Capture opens on a frame boundary so no partial frame reaches memory
				next_fcnt = '0;
				if (stop_sw_i) begin
					next_state = ACQ_IDLE;
				end else if (frame_tick) begin
					next_state = ACQ_RUN;
				end
			end
			ACQ_RUN: begin
				if (stop_sw_i) begin
					next_fcnt = '0;
					next_state = (stop_delay_i == '0) ? ACQ_IDLE : ACQ_STOP_WAIT;
				end else if (frame_tick) begin
					next_fcnt = fcnt + 12'h001;
					next_chan = (chan == LAST_CHAN) ? 2'h0 : chan + 2'h1;
					if (frame_count_i != '0 && fcnt + 12'h001 >= frame_count_i) begin
						next_state = ACQ_IDLE;
					end
				end
			end
			default: begin
				if (frame_tick) begin
					next_fcnt = fcnt + 12'h001;
					next_chan = (chan == LAST_CHAN) ? 2'h0 : chan + 2'h1;
					if (fcnt + 12'h001 >= stop_delay_i) begin
						next_state = ACQ_IDLE;
					end
				end
			end
		endcase
	end

	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			state <= ACQ_IDLE;
			fcnt <= '0;
			chan <= '0;
		end else begin
			state <= next_state;
			fcnt <= next_fcnt;
			chan <= next_chan;
		end
	end

	// Window and decimation decision, then byte packing group
	logic [CNT_W-1:0] hx, ly, dx, dy, out_line;
	logic             keep, line_end;
	logic             last_px;                  // No later pixel of this line can be kept
	logic [31:0]      pk_data, next_pk_data;
	logic [1:0]       pk_idx, next_pk_idx;
	logic             pk_sof, next_pk_sof;
	logic             emit, next_emit, ovf, next_ovf;
	word_t            emit_word, next_emit_word;
	logic             fifo_full;

	always_comb begin
		capturing = (state == ACQ_RUN) || (state == ACQ_STOP_WAIT);
		hx = hcnt - acq_h_i.start;
		ly = vcnt - acq_v_i.start;
		dx = roi_en_i ? hx - roi_h_i.start : hx;
		dy = roi_en_i ? ly - roi_v_i.start : ly;
		// Line 0 of the window is line 1, so odd lines have an even offset
		keep = capturing && pix_en && !vs_edge
			&& in_win(hcnt, acq_h_i) && in_win(vcnt, acq_v_i)
			&& (!roi_en_i || (in_win(hx, roi_h_i) && in_win(ly, roi_v_i)))
			&& ((dx[2:0] & dec_mask(hdec_i)) == 3'h0)
			&& ((dy[2:0] & dec_mask(vdec_i)) == 3'h0);
		line_end = pix_en && (hcnt == acq_h_i.start + acq_h_i.len);
		// The next kept pixel lies one decimation step on; past either window end, this word closes the line
		last_px = ({1'b0, hcnt} + {10'h0, dec_mask(hdec_i)} + 13'h001
			>= {1'b0, acq_h_i.start} + {1'b0, acq_h_i.len})
			|| (roi_en_i && ({1'b0, dx} + {10'h0, dec_mask(hdec_i)} + 13'h001 >= {1'b0, roi_h_i.len}));
		// Interlaced fields interleave into one frame: first field odd rows, second even
		out_line = interlaced_i ? CNT_W'({dy, !field_first}) : dy;
		next_pk_data = pk_data;
		next_pk_idx = pk_idx;
		next_pk_sof = pk_sof || (frame_tick && next_state == ACQ_RUN);
		next_emit = 1'b0;
		next_emit_word = emit_word;
		next_ovf = ovf && !start_req;
		if (keep) begin
			next_pk_data[pk_idx*8 +: 8] = sample_lookup_table[sample_i];
			next_pk_idx = pk_idx + 2'h1;
			if (pk_idx == LAST_BYTE) begin
				next_emit = 1'b1;
			end
		end else if (line_end && pk_idx != 2'h0) begin
			next_emit = 1'b1;   // Partial word closes the line
			next_pk_idx = 2'h0;
		end
		if (next_emit) begin
			next_emit_word.data = next_pk_data;
			// A partial word holds pk_idx bytes, so that many low enables are set
			next_emit_word.be = (pk_idx == LAST_BYTE && keep) ? 4'hf : {1'b0, dec_mask(pk_idx)};
			next_emit_word.chan = chan;
			next_emit_word.line = out_line;
			next_emit_word.sof = pk_sof;
			next_emit_word.eol = !keep || last_px;
			next_pk_sof = 1'b0;
		end
		// Video cannot be stalled, so a full store drops the word and flags it
		if (emit && fifo_full) begin
			next_ovf = 1'b1;
		end
		if (!capturing) begin
			next_pk_idx = 2'h0;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			pk_data <= '0;
			pk_idx <= '0;
			pk_sof <= 1'b0;
			emit <= 1'b0;
			emit_word <= '0;
			ovf <= 1'b0;
		end else begin
			pk_data <= next_pk_data;
			pk_idx <= next_pk_idx;
			pk_sof <= next_pk_sof;
			emit <= next_emit;
			emit_word <= next_emit_word;
			ovf <= next_ovf;
		end
	end

	// Lookup table write port; software loads the transfer function
	always_ff @(posedge core_clk_i) begin
		if (lut_we_i) begin
			sample_lookup_table[lut_addr_i] <= lut_data_i;
		end
	end

	// Store and two-entry output buffer group
	logic [FIFO_AW:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
	logic [1:0]       sk_cnt, next_sk_cnt;
	word_t            sk0, sk1, next_sk0, next_sk1;
	logic             fifo_empty, fifo_wr, fifo_rd, sk_pop;

	always_comb begin
		fifo_full = (wr_ptr[FIFO_AW] != rd_ptr[FIFO_AW]) && (wr_ptr[FIFO_AW-1:0] == rd_ptr[FIFO_AW-1:0]);
		fifo_empty = (wr_ptr == rd_ptr);
		fifo_wr = emit && !fifo_full;
		sk_pop = out_valid_o && out_ready_i;
		// Buffer refills only with room after the pop, so a stalled receiver backs up the store
		fifo_rd = !fifo_empty && (sk_cnt != 2'h2 || sk_pop);
		next_wr_ptr = wr_ptr + (FIFO_AW+1)'(fifo_wr);
		next_rd_ptr = rd_ptr + (FIFO_AW+1)'(fifo_rd);
		next_sk0 = sk0;
		next_sk1 = sk1;
		next_sk_cnt = sk_cnt - 2'(sk_pop) + 2'(fifo_rd);
		if (sk_pop) begin
			next_sk0 = sk1;
		end
		if (fifo_rd) begin
			if (next_sk_cnt == 2'h1) begin
				next_sk0 = fifo_mem[rd_ptr[FIFO_AW-1:0]];
			end else begin
				next_sk1 = fifo_mem[rd_ptr[FIFO_AW-1:0]];
			end
		end
		out_valid_o = (sk_cnt != 2'h0);
		out_word_o = sk0;
		acq_busy_o = (state != ACQ_IDLE);
		overflow_o = ovf;
	end

	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			sk_cnt <= '0;
			sk0 <= '0;
			sk1 <= '0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			sk_cnt <= next_sk_cnt;
			sk0 <= next_sk0;
			sk1 <= next_sk1;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (fifo_wr) begin
			fifo_mem[wr_ptr[FIFO_AW-1:0]] <= emit_word;
		end
	end

	// Checks
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (srst_i);
	lut_lookup_a: assert property (keep && !lut_we_i |=> pk_data[$past(pk_idx)*8 +: 8]
		== sample_lookup_table[$past(sample_i)]) else $error("lookup output mismatch");
	composite_sync_gate_a: assert property (sync_src_ext_i |-> composite_sync_oe_n_o) else $error("sync driven in external mode");
	step_range_a: assert property (step_eff >= STEP_MIN && step_eff <= STEP_MAX) else $error("pixel rate out of range");
	htotal_wrap_a: assert property (pix_en && !vs_edge && hcnt == htotal_i - 12'h001 |=> hcnt == '0)
		else $error("line did not wrap at total");
	hwin_keep_a: assert property (keep |-> hcnt >= acq_h_i.start && vcnt >= acq_v_i.start)
		else $error("pixel kept outside window");
	vtotal_wrap_a: assert property (hs_edge && !vs_edge && vcnt >= line_total_i - 12'h001 |=> vcnt == '0)
		else $error("field did not wrap at line total");
	idle_drop_a: assert property (state == ACQ_IDLE |-> !keep) else $error("pixel kept while idle");
	hdec_step_a: assert property (keep && hdec_i == 2'h3 |-> dx[2:0] == 3'h0) else $error("decimation broken");
	external_trigger_line_drive_a: assert property (!external_trigger_line_dir_in_i && external_trigger_line_mode_i == EXTERNAL_TRIGGER_LINE_OUT_HIGH |-> !external_trigger_line_oe_n_o && external_trigger_line_out_o)
		else $error("trigger output level wrong");
	store_full_a: assert property (fifo_full |-> !fifo_wr ##1 $stable(wr_ptr)) else $error("write into full store");
	run_cov: cover property (state == ACQ_ARMED ##1 state == ACQ_RUN);
	full_cov: cover property (fifo_full && emit);
	roi_cov: cover property (keep && roi_en_i && hdec_i != 2'h0);
endmodule : mono_capture_core
`default_nettype wire

// ### mono_capture_far_model.sv
// Far-side model: camera syncs and samples plus the host that takes captured words
`timescale 1ns/1ps
`default_nettype none
module mono_capture_far_model import mono_capture_pkg::*; (
	input  wire logic       clk_i,
	input  wire logic       clear_i,   // Zero the tallies
	input  wire logic       stall_i,   // Host refuses words
	output logic            hsync_o,
	output logic            vsync_o,
	output logic [7:0]      sample_o,
	input  wire word_t      word_i,
	input  wire logic       valid_i,
	output logic            ready_o,
	input  wire logic [7:0] exp_i,     // Byte expected after the lookup
	output var int          lines_o,
	output var int          bytes_o,
	output var int          bad_o
);
	int hc = 0;  // Core cycles within a line
	int lc = 0;  // Lines within a field
	// One grey level, so expectations hold whatever the pixel phase
	assign sample_o = 8'h5a;
	assign hsync_o  = hc < 8;
	assign vsync_o  = lc == 0 && hc < 200;
	assign ready_o  = !stall_i;
	// Free-running lines of 400 cycles, eight lines a field
	always @(posedge clk_i) begin
		hc <= (hc == 399) ? 0 : hc + 1;
		if (hc == 399)
			lc <= (lc == 7) ? 0 : lc + 1;
	end
	// Tally each accepted word byte by byte; a stall only delays words
	always @(posedge clk_i) begin
		int n;
		int e;
		n = 0;
		e = 0;
		for (int b = 0; b < 4; b++) begin
			if (word_i.be[b]) begin
				n++;
				if (word_i.data[8*b +: 8] !== exp_i)
					e++;
			end
		end
		if (clear_i) begin
			lines_o <= 0;
			bytes_o <= 0;
			bad_o   <= 0;
		end else if (valid_i && ready_o) begin
			bytes_o <= bytes_o + n;
			bad_o   <= bad_o + e;
			if (word_i.eol)
				lines_o <= lines_o + 1;
		end
	end
endmodule : mono_capture_far_model
`default_nettype wire

// ### tb_mono_capture_core.sv
// Testbench for the monochrome capture core
`timescale 1ns/1ps
`default_nettype none
module tb_mono_capture_core;
	import mono_capture_pkg::*;
	logic clk = 0, srst = 1, hs, vs, ext_src = 0, cs_en = 0, cs_o, cs_oe_n;
	logic lut_we = 0, roi_en = 0, start = 0, stop = 0, external_trigger_line_in = 0, external_trigger_line_out, external_trigger_line_oe_n;
	logic external_trigger_line_dir_in = 1, external_trigger_line_rise = 0, busy, ovf, valid, ready, stall = 0, clear = 1;
	logic [7:0] sample, lut_addr = 0, lut_data = 0;
	logic [1:0] hdec = 0, vdec = 0;
	logic ilace = 0, odd_first = 0;
	// Horizontal total above the pixels in a model line, so the flywheel only covers a missing sync
	logic [CNT_W-1:0] fcount = 12'h001, htot = 12'h033, sdelay = 12'h000, pdelay = 12'h000;
	win_t ah = '{12'h008, 12'h010}, av = '{12'h002, 12'h003};  // Acquisition window
	win_t rh = '{12'h004, 12'h008}, rv = '{12'h001, 12'h002};  // Region, relative
	external_trigger_line_out_t external_trigger_line_mode = EXTERNAL_TRIGGER_LINE_OUT_LOW;
	word_t word;
	int lines, bytes, bad, mismatches = 0, n_compared = 0;
	// 250 MHz core clock
	always #2 clk = ~clk;
	mono_capture_core mono_capture_core_i (.core_clk_i(clk), .srst_i(srst), .sample_i(sample),
		.video_hsync_i(hs), .video_vsync_i(vs), .ext_hsync_i(hs), .ext_vsync_i(vs),
		.sync_src_ext_i(ext_src), .composite_sync_out_en_i(cs_en), .composite_sync_o(cs_o),
		.composite_sync_oe_n_o(cs_oe_n), .lut_we_i(lut_we), .lut_addr_i(lut_addr),
		.lut_data_i(lut_data), .pix_step_i(16'h1fbe), .htotal_i(htot), .line_total_i(12'h008),
		.acq_h_i(ah), .acq_v_i(av), .roi_en_i(roi_en), .roi_h_i(rh), .roi_v_i(rv), .hdec_i(hdec),
		.vdec_i(vdec), .interlaced_i(ilace), .start_odd_i(odd_first), .start_sw_i(start),
		.stop_sw_i(stop), .frame_count_i(fcount), .start_delay_i(sdelay), .stop_delay_i(pdelay),
		.external_trigger_line_in_i(external_trigger_line_in), .external_trigger_line_out_o(external_trigger_line_out), .external_trigger_line_oe_n_o(external_trigger_line_oe_n),
		.external_trigger_line_dir_in_i(external_trigger_line_dir_in), .external_trigger_line_rise_i(external_trigger_line_rise), .external_trigger_line_mode_i(external_trigger_line_mode),
		.acq_busy_o(busy), .overflow_o(ovf), .out_word_o(word), .out_valid_o(valid),
		.out_ready_i(ready));
	mono_capture_far_model mono_capture_far_model_i (.clk_i(clk), .clear_i(clear), .stall_i(stall),
		.hsync_o(hs), .vsync_o(vs), .sample_o(sample), .word_i(word), .valid_i(valid),
		.ready_o(ready), .exp_i(~8'h5a), .lines_o(lines), .bytes_o(bytes), .bad_o(bad));
	// Inputs move 1 ns after the rising edge
	task automatic tick;
		@(posedge clk);
		#1;
	endtask : tick
	task automatic pulse(ref logic s);
		s = 1;
		tick;
		s = 0;
	endtask : pulse
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		n_compared++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %0t %s: saw %h want %h", $time, what, seen, exp);
		end
	endtask : check
	task automatic final_report;
		$display("Compared %0d, mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : final_report
	// Bounded wait; running out ends the run as a failure
	task automatic wait_for(input logic want, input int which, input int limit);
		int k;
		k = 0;
		while ((which == 0 ? busy : which == 1 ? hs : vs) !== want) begin
			tick;
			if (++k == limit) begin
				mismatches++;
				$display("[FAIL] %0t wait ran out", $time);
				final_report;
			end
		end
	endtask : wait_for
	task automatic t_reset;
		check(valid, 0, "valid");
		check(busy, 0, "busy");
		check(ovf, 0, "overflow");
		check({31'h0, |word}, 0, "word");
		$display("test reset done");
	endtask : t_reset
	// Inverting table, so every stored byte must be the complement of the sample
	task automatic load_lut;
		for (int a = 0; a < LUT_DEPTH; a++) begin
			lut_we = 1;
			lut_addr = 8'(a);
			lut_data = ~8'(a);
			tick;
		end
		lut_we = 0;
	endtask : load_lut
	task automatic t_sync;
		for (int i = 0; i < 4; i++) begin
			{ext_src, cs_en} = 2'(i);
			tick;
			check(cs_oe_n, !(cs_en && !ext_src), "sync drive");
			check(cs_o, hs | vs, "composite sync");
		end
		{ext_src, cs_en} = 2'h0;
		// A short total makes the flywheel wrap lines between syncs for the wrap assertion
		htot = 12'h008;
		repeat (400) tick;
		htot = 12'h033;
		$display("test sync done");
	endtask : t_sync
	task automatic t_external_trigger_line_out;
		external_trigger_line_dir_in = 0;
		for (int m = 0; m < 4; m++) begin
			external_trigger_line_mode = external_trigger_line_out_t'(m);
			tick;
			check(external_trigger_line_oe_n, 0, "trigger drive");
			if (m < 2) begin
				check(external_trigger_line_out, m, "trigger level");
			end else begin
				wait_for(0, m - 1, 4000);
				wait_for(1, m - 1, 4000);
				repeat (3) tick;
				check(external_trigger_line_out, 1, "trigger sync high");
				repeat (m == 2 ? 20 : 300) tick;
				check(external_trigger_line_out, 0, "trigger sync low");
			end
		end
		external_trigger_line_dir_in = 1;
		tick;
		check(external_trigger_line_oe_n, 1, "trigger input");
		$display("test trigger output done");
	endtask : t_external_trigger_line_out
	task automatic t_start_stop;
		fcount = 12'h000;
		// A start delay parks the sequencer in its wait, where a stop must still end it
		sdelay = 12'h002;
		pulse(start);
		check(busy, 1, "start");
		pulse(start);
		check(busy, 1, "second start");
		pulse(stop);
		repeat (2) tick;
		check(busy, 0, "immediate stop");
		sdelay = 12'h000;
		fcount = 12'h001;
		$display("test start stop done");
	endtask : t_start_stop
	task automatic t_external_trigger_line_start(input logic rise);
		fcount = 12'h000;
		external_trigger_line_rise = rise;
		external_trigger_line_in = rise;
		repeat (6) tick;
		pulse(stop);
		repeat (6) tick;
		external_trigger_line_in = !rise;
		repeat (6) tick;
		check(busy, 0, "wrong edge");
		external_trigger_line_in = rise;
		repeat (6) tick;
		check(busy, 1, "trigger start");
		pulse(stop);
		repeat (6) tick;
		fcount = 12'h001;
		$display("test trigger start done");
	endtask : t_external_trigger_line_start
	// One frame through windows, region, decimation and a stalling host
	task automatic t_capture(input logic [1:0] d, input logic [1:0] v, input logic r, input logic s, input logic x);
		int nl;
		int nb;
		nl = ((r ? rv.len : av.len) + (1 << v) - 1) >> v;
		nb = nl * ((r ? rh.len : ah.len) >> d);
		{hdec, vdec, roi_en, stall, ext_src} = {d, v, r, s, x};
		pulse(clear);
		pulse(start);
		wait_for(0, 0, 30000);
		stall = 0;
		repeat (300) tick;
		check(lines, nl, "lines");
		check(bytes, nb, "bytes");
		check(bad, 0, "pixel values");
		check(ovf, 0, "no loss");
		check(valid, 0, "drained");
		$display("test capture done");
	endtask : t_capture
	initial begin
		repeat (3) @(posedge clk);
		#1;
		srst = 0;
		clear = 0;
		t_reset;
		load_lut;
		t_sync;
		t_external_trigger_line_out;
		t_start_stop;
		t_external_trigger_line_start(1);
		t_external_trigger_line_start(0);
		t_capture(2'h0, 2'h0, 0, 0, 0);
		t_capture(2'h1, 2'h0, 1, 0, 0);
		t_capture(2'h3, 2'h1, 0, 1, 0);
		t_capture(2'h2, 2'h0, 1, 0, 1);
		final_report;
	end
endmodule : tb_mono_capture_core
`default_nettype wire
